/* File: hdl/rctim_top.sv */
/*
  Reload/capture timer set: timer two (reload, capture, baud clock),
  timers three and four (16-bit reload/free-run) and timer five
  (24-bit, oscillator ticked), all behind one APB slave.
  Assumes pins and oscillators are asynchronous and slower than half
  the system clock; the timer one overflow pulse is on clock_i.
*/
// How it works
// - Timer two free counts 16 bits; overflow sets flag outside baud mode and reloads, or clears to zero in capture mode
// - Auto-reload mode also reloads on event pin fall when enabled
// - Capture mode flags overflow and copies count on event pin fall
// - Baud select makes overflows the serial clock, forces reload
// - Receive/transmit selects pick timer two or timer one overflows
// - One pin serves as both count input and event input
// - Timers three and four: 16-bit, system clocked, reload or free-run
// - Timer three/four overflow sets a flag, kept until software clears
// - Mode bit one means reload, zero means free-run
// - Run bit advances counter, clear holds it
// - Interrupt enable gates the overflow request
// - Count writes go to reload or live count; reads live count
// - Timer five: 24-bit, reload or free-run, oscillator ticked
// - Timer five keeps counting in low power modes
// - Clock select 0x picks fast oscillator, 1x the 32 kHz one
// - Timer five overflow sets flag; with enable it requests irq
// - Timer five mode bit picks reload; run bit starts and stops
// - Timer five byte writes go to reload or live count
// - Timer mode steps every 12 clocks, or 2 in baud mode
// - Counter mode steps on each falling edge of the count pin
`timescale 1ns/1ns
module rctim_top
  import rctim_pkg::*;
(
  input  wire logic           clock_i,            // System clock
  input  wire logic           rst_i,              // Synchronous reset
  input  wire rctim_apb_req_t apb_i,              // APB request
  output rctim_apb_rsp_t      apb_o,              // APB response
  input  wire logic           timer2_count_pin_i, // Count and event pin
  input  wire logic           fast_internal_osc_i,// Fast oscillator
  input  wire logic           slow_32k_osc_i,     // 32 kHz oscillator
  input  wire logic           timer1_overflow_i,  // Timer one overflow pulse
  output logic                rx_baud_tick_o,     // Receiver bit clock
  output logic                tx_baud_tick_o,     // Transmitter bit clock
  output logic                timer2_irq_o,       // Timer two request
  output logic                timer3_irq_o,       // Timer three request
  output logic                timer4_irq_o,       // Timer four request
  output logic                timer5_irq_o        // Timer five request
);

  rctim_state_t s;
  rctim_state_t next_s;

  logic [15:0] idx;
  logic        hit;
  logic        wr;
  logic [7:0]  wb;
  logic [7:0]  rd_byte;
  logic        t2_baud;
  logic        t2_run;
  logic        t2_fall;
  logic        t2_pre_hit;
  logic        t2_tick;
  logic        t2_ovf;
  logic        t2_evt;
  logic        t3_ovf;
  logic        t4_ovf;
  logic        t5_edge;
  logic        t5_tick;
  logic        t5_ovf;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and read mux

  assign idx = apb_i.paddr[17:2];
  assign wb  = apb_i.pwdata[7:0];
  assign wr  = apb_i.psel && apb_i.penable && apb_i.pwrite && hit;

  always_comb begin
    hit     = (apb_i.paddr[1:0] == 2'h0);
    rd_byte = 8'h00;
    if (idx == IDX_T4_LOW) begin
      rd_byte = s.t4_cnt[7:0];
    end else if (idx == IDX_T4_HIGH) begin
      rd_byte = s.t4_cnt[15:8];
    end else if (idx == IDX_T3_LOW) begin
      rd_byte = s.t3_cnt[7:0];
    end else if (idx == IDX_T3_HIGH) begin
      rd_byte = s.t3_cnt[15:8];
    end else if (idx == IDX_T2_CTRL) begin
      rd_byte = s.t2_ctrl;
    end else if (idx == IDX_T2_TIMER2_RELOAD_LOW) begin
      rd_byte = s.t2_rld[7:0];
    end else if (idx == IDX_T2_TIMER2_RELOAD_HIGH) begin
      rd_byte = s.t2_rld[15:8];
    end else if (idx == IDX_T2_LOW) begin
      rd_byte = s.t2_cnt[7:0];
    end else if (idx == IDX_T2_HIGH) begin
      rd_byte = s.t2_cnt[15:8];
    end else if (idx == IDX_T34_CTL) begin
      rd_byte = s.t34_ctrl;
    end else if (idx == IDX_T5_CTRL) begin
      rd_byte = s.t5_ctrl;
    end else if (idx == IDX_T5_LOW) begin
      rd_byte = s.t5_cnt[7:0];
    end else if (idx == IDX_T5_MID) begin
      rd_byte = s.t5_cnt[15:8];
    end else if (idx == IDX_T5_TOP) begin
      rd_byte = s.t5_cnt[23:16];
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event decode

  assign t2_baud    = s.t2_ctrl[T2_RX_BAUD] || s.t2_ctrl[T2_TX_BAUD];
  assign t2_run     = s.t2_ctrl[T2_RUN];
  // Shared pin feeds both count and event paths
  assign t2_fall    = s.t2_pin[2] && !s.t2_pin[1];
  assign t2_pre_hit = (s.t2_pre == ((t2_baud ? T2_DIV_BAUD : T2_DIV_STD) - 4'h1));
  assign t2_tick    = t2_run && (s.t2_ctrl[T2_CNT_SEL] ? t2_fall : t2_pre_hit);
  assign t2_ovf     = t2_tick && (s.t2_cnt == 16'hffff);
  assign t2_evt     = s.t2_ctrl[T2_EVT_EN] && t2_fall;
  assign t3_ovf     = s.t34_ctrl[T3_RUN] && (s.t3_cnt == 16'hffff);
  assign t4_ovf     = s.t34_ctrl[T3_RUN + T4_OFS] && (s.t4_cnt == 16'hffff);
  // No power mode input gates this path
  assign t5_edge    = s.t5_ctrl[T5_CLK_SEL_H] ? (s.slow_sync[1] && !s.slow_sync[2])
                                              : (s.fast_sync[1] && !s.fast_sync[2]);
  assign t5_tick    = s.t5_ctrl[T5_RUN] && t5_edge;
  assign t5_ovf     = t5_tick && (s.t5_cnt == 24'hffffff);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;

    // Read data captured in setup, so the access phase answers at once
    if (apb_i.psel && !apb_i.penable) begin
      next_s.prdata  = {24'h000000, rd_byte};
      next_s.pslverr = !hit;
    end

    // Synchronisers: first stage feeds only the second
    next_s.t2_pin    = {s.t2_pin[1:0], timer2_count_pin_i};
    next_s.fast_sync = {s.fast_sync[1:0], fast_internal_osc_i};
    next_s.slow_sync = {s.slow_sync[1:0], slow_32k_osc_i};

    // Timer two prescaler
    if (t2_run && !s.t2_ctrl[T2_CNT_SEL]) begin
      next_s.t2_pre = t2_pre_hit ? 4'h0 : s.t2_pre + 4'h1;
    end else begin
      next_s.t2_pre = 4'h0;
    end

    // Timer two count
    if (t2_ovf) begin
      if (t2_baud || !s.t2_ctrl[T2_CAP_SEL]) begin
        next_s.t2_cnt = s.t2_rld;
      end else begin
        next_s.t2_cnt = 16'h0000;
      end
    end else if (t2_tick) begin
      next_s.t2_cnt = s.t2_cnt + 16'h0001;
    end
    if (t2_run && !t2_baud && !s.t2_ctrl[T2_CAP_SEL] && t2_evt) begin
      next_s.t2_cnt = s.t2_rld;
    end
    if (wr && idx == IDX_T2_LOW) begin
      next_s.t2_cnt[7:0] = wb;
    end
    if (wr && idx == IDX_T2_HIGH) begin
      next_s.t2_cnt[15:8] = wb;
    end

    // Timer two reload bytes; a capture beats a same-cycle write
    if (wr && idx == IDX_T2_TIMER2_RELOAD_LOW) begin
      next_s.t2_rld[7:0] = wb;
    end
    if (wr && idx == IDX_T2_TIMER2_RELOAD_HIGH) begin
      next_s.t2_rld[15:8] = wb;
    end
    if (t2_run && !t2_baud && s.t2_ctrl[T2_CAP_SEL] && t2_evt) begin
      next_s.t2_rld = s.t2_cnt;
    end

    // Timer two control; hardware sets win over software clears
    if (wr && idx == IDX_T2_CTRL) begin
      next_s.t2_ctrl = wb;
    end
    if (t2_ovf && !t2_baud) begin
      next_s.t2_ctrl[T2_OVF_FLAG] = 1'b1;
    end
    if (t2_evt) begin
      next_s.t2_ctrl[T2_EVT_FLAG] = 1'b1;
    end

    // Serial bit clocks
    next_s.rx_tick = s.t2_ctrl[T2_RX_BAUD] ? t2_ovf : timer1_overflow_i;
    next_s.tx_tick = s.t2_ctrl[T2_TX_BAUD] ? t2_ovf : timer1_overflow_i;

    // Timers three and four count every system clock while running
    if (t3_ovf) begin
      next_s.t3_cnt = s.t34_ctrl[T3_MODE] ? s.t3_rld : 16'h0000;
    end else if (s.t34_ctrl[T3_RUN]) begin
      next_s.t3_cnt = s.t3_cnt + 16'h0001;
    end
    if (t4_ovf) begin
      next_s.t4_cnt = s.t34_ctrl[T3_MODE + T4_OFS] ? s.t4_rld : 16'h0000;
    end else if (s.t34_ctrl[T3_RUN + T4_OFS]) begin
      next_s.t4_cnt = s.t4_cnt + 16'h0001;
    end
    // Byte writes land in reload or live count by mode
    if (wr && idx == IDX_T3_LOW) begin
      if (s.t34_ctrl[T3_MODE]) begin
        next_s.t3_rld[7:0] = wb;
      end else begin
        next_s.t3_cnt[7:0] = wb;
      end
    end
    if (wr && idx == IDX_T3_HIGH) begin
      if (s.t34_ctrl[T3_MODE]) begin
        next_s.t3_rld[15:8] = wb;
      end else begin
        next_s.t3_cnt[15:8] = wb;
      end
    end
    if (wr && idx == IDX_T4_LOW) begin
      if (s.t34_ctrl[T3_MODE + T4_OFS]) begin
        next_s.t4_rld[7:0] = wb;
      end else begin
        next_s.t4_cnt[7:0] = wb;
      end
    end
    if (wr && idx == IDX_T4_HIGH) begin
      if (s.t34_ctrl[T3_MODE + T4_OFS]) begin
        next_s.t4_rld[15:8] = wb;
      end else begin
        next_s.t4_cnt[15:8] = wb;
      end
    end
    if (wr && idx == IDX_T34_CTL) begin
      next_s.t34_ctrl = wb;
    end
    if (t3_ovf) begin
      next_s.t34_ctrl[T3_OVF_FLAG] = 1'b1;
    end
    if (t4_ovf) begin
      next_s.t34_ctrl[T3_OVF_FLAG + T4_OFS] = 1'b1;
    end

    // Timer five
    if (t5_ovf) begin
      next_s.t5_cnt = s.t5_ctrl[T5_MODE] ? s.t5_rld : 24'h000000;
    end else if (t5_tick) begin
      next_s.t5_cnt = s.t5_cnt + 24'h000001;
    end
    if (wr && idx == IDX_T5_LOW) begin
      if (s.t5_ctrl[T5_MODE]) begin
        next_s.t5_rld[7:0] = wb;
      end else begin
        next_s.t5_cnt[7:0] = wb;
      end
    end
    if (wr && idx == IDX_T5_MID) begin
      if (s.t5_ctrl[T5_MODE]) begin
        next_s.t5_rld[15:8] = wb;
      end else begin
        next_s.t5_cnt[15:8] = wb;
      end
    end
    if (wr && idx == IDX_T5_TOP) begin
      if (s.t5_ctrl[T5_MODE]) begin
        next_s.t5_rld[23:16] = wb;
      end else begin
        next_s.t5_cnt[23:16] = wb;
      end
    end
    if (wr && idx == IDX_T5_CTRL) begin
      next_s.t5_ctrl = wb & T5_CTRL_MASK;
    end
    if (t5_ovf) begin
      next_s.t5_ctrl[T5_OVF_FLAG] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      next_s_reset_block: begin
        s           <= '0;
        s.t2_ctrl   <= REG_RST;
        s.t34_ctrl  <= REG_RST;
        s.t5_ctrl   <= REG_RST;
        s.t2_pin    <= PIN_SYNC_RST;
        s.fast_sync <= OSC_SYNC_RST;
        s.slow_sync <= OSC_SYNC_RST;
      end
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign apb_o.prdata  = s.prdata;
  assign apb_o.pready  = 1'b1;
  assign apb_o.pslverr = s.pslverr && apb_i.psel && apb_i.penable;
  assign rx_baud_tick_o = s.rx_tick;
  assign tx_baud_tick_o = s.tx_tick;
  assign timer2_irq_o  = s.t2_ctrl[T2_OVF_FLAG] || s.t2_ctrl[T2_EVT_FLAG];
  assign timer3_irq_o  = s.t34_ctrl[T3_OVF_FLAG] && s.t34_ctrl[T3_IRQ_EN];
  assign timer4_irq_o  = s.t34_ctrl[T3_OVF_FLAG + T4_OFS]
                         && s.t34_ctrl[T3_IRQ_EN + T4_OFS];
  assign timer5_irq_o  = s.t5_ctrl[T5_OVF_FLAG] && s.t5_ctrl[T5_IRQ_EN];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic t2_quiet;
  logic t3_quiet;
  assign t2_quiet = t2_run && !s.t2_ctrl[T2_CNT_SEL] && !t2_baud && !wr;
  assign t3_quiet = !(wr && (idx == IDX_T3_LOW || idx == IDX_T3_HIGH));

  property p_t2_reload;
    @(posedge clock_i) disable iff (rst_i)
    (t2_ovf && !t2_baud && !s.t2_ctrl[T2_CAP_SEL] && !wr)
      |=> s.t2_ctrl[T2_OVF_FLAG] && (s.t2_cnt == $past(s.t2_rld));
  endproperty
  a_t2_reload: assert property (p_t2_reload) else $error("t2 reload failed");

  property p_t2_capture;
    @(posedge clock_i) disable iff (rst_i)
    (t2_run && !t2_baud && s.t2_ctrl[T2_CAP_SEL] && t2_evt) |=> s.t2_rld == $past(s.t2_cnt);
  endproperty
  a_t2_capture: assert property (p_t2_capture) else $error("t2 capture missed");

  property p_t2_baud;
    @(posedge clock_i) disable iff (rst_i)
    (t2_ovf && s.t2_ctrl[T2_RX_BAUD] && !s.t2_ctrl[T2_OVF_FLAG] && !wr)
      |=> rx_baud_tick_o && !s.t2_ctrl[T2_OVF_FLAG] && s.t2_cnt == $past(s.t2_rld);
  endproperty
  a_t2_baud: assert property (p_t2_baud) else $error("t2 baud overflow wrong");

  property p_t2_prescale;
    @(posedge clock_i) disable iff (rst_i)
    (t2_quiet && t2_tick) |=> ((!t2_quiet) || !t2_tick)[*8];
  endproperty
  a_t2_prescale: assert property (p_t2_prescale) else $error("t2 steps too fast");

  property p_t2_stop;
    @(posedge clock_i) disable iff (rst_i)
    (!t2_run && !wr) |=> $stable(s.t2_cnt) && !$rose(s.t2_ctrl[T2_OVF_FLAG]);
  endproperty
  a_t2_stop: assert property (p_t2_stop) else $error("stopped t2 moved");

  property p_t2_event;
    @(posedge clock_i) disable iff (rst_i)
    t2_evt |=> s.t2_ctrl[T2_EVT_FLAG] && timer2_irq_o;
  endproperty
  a_t2_event: assert property (p_t2_event) else $error("event flag lost");

  property p_t3_wrap;
    @(posedge clock_i) disable iff (rst_i)
    (t3_ovf && t3_quiet)
      |=> s.t34_ctrl[T3_OVF_FLAG]
          && (s.t3_cnt == ($past(s.t34_ctrl[T3_MODE]) ? $past(s.t3_rld) : 16'h0000));
  endproperty
  a_t3_wrap: assert property (p_t3_wrap) else $error("t3 wrap wrong");

  property p_t3_hold;
    @(posedge clock_i) disable iff (rst_i)
    (!s.t34_ctrl[T3_RUN] && t3_quiet) |=> $stable(s.t3_cnt);
  endproperty
  a_t3_hold: assert property (p_t3_hold) else $error("stopped t3 moved");

  property p_t4_step;
    @(posedge clock_i) disable iff (rst_i)
    (s.t34_ctrl[T3_RUN + T4_OFS] && !t4_ovf && !wr) |=> s.t4_cnt == $past(s.t4_cnt) + 16'h0001;
  endproperty
  a_t4_step: assert property (p_t4_step) else $error("t4 did not step");

  property p_t5_flag;
    @(posedge clock_i) disable iff (rst_i)
    (t5_ovf && s.t5_ctrl[T5_IRQ_EN] && !wr) |=> timer5_irq_o && s.t5_ctrl[T5_OVF_FLAG];
  endproperty
  a_t5_flag: assert property (p_t5_flag) else $error("t5 request missing");

  c_t2_reload:  cover property (@(posedge clock_i) disable iff (rst_i)
                               t2_ovf && !t2_baud && !s.t2_ctrl[T2_CAP_SEL]);
  c_t2_capture: cover property (@(posedge clock_i) disable iff (rst_i)
                               t2_evt && s.t2_ctrl[T2_CAP_SEL] && t2_run);
  c_t3_reload:  cover property (@(posedge clock_i) disable iff (rst_i)
                               t3_ovf && s.t34_ctrl[T3_MODE]);
  c_t5_ovf:     cover property (@(posedge clock_i) disable iff (rst_i) t5_ovf);

endmodule

/* File: include/rctim_pkg.sv */
/*
  Package for the reload/capture timer set: register indexes, control
  bit positions, reset values, cycle counts and the carrier types.
  Assumes a 32-bit APB master and one 100 MHz system clock.
*/
package rctim_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indexes; byte address is four times the index
  localparam int unsigned ADDR_W      = 18;
  localparam logic [15:0] IDX_T4_LOW  = 16'h00ac;
  localparam logic [15:0] IDX_T4_HIGH = 16'h00ad;
  localparam logic [15:0] IDX_T3_LOW  = 16'h00ae;
  localparam logic [15:0] IDX_T3_HIGH = 16'h00af;
  localparam logic [15:0] IDX_T2_CTRL = 16'h00c8;
  localparam logic [15:0] IDX_T2_TIMER2_RELOAD_LOW = 16'h00ca;
  localparam logic [15:0] IDX_T2_TIMER2_RELOAD_HIGH = 16'h00cb;
  localparam logic [15:0] IDX_T2_LOW  = 16'h00cc;
  localparam logic [15:0] IDX_T2_HIGH = 16'h00cd;
  localparam logic [15:0] IDX_T34_CTL = 16'h00cf;
  localparam logic [15:0] IDX_T5_CTRL = 16'ha068;
  localparam logic [15:0] IDX_T5_LOW  = 16'ha069;
  localparam logic [15:0] IDX_T5_MID  = 16'ha06a;
  localparam logic [15:0] IDX_T5_TOP  = 16'ha06b;

  ////////////////////////////////////////////////////////////////////////////
  // Timer two control bits
  localparam int unsigned T2_OVF_FLAG  = 7;
  localparam int unsigned T2_EVT_FLAG  = 6;
  localparam int unsigned T2_RX_BAUD   = 5;
  localparam int unsigned T2_TX_BAUD   = 4;
  localparam int unsigned T2_EVT_EN    = 3;
  localparam int unsigned T2_RUN       = 2;
  localparam int unsigned T2_CNT_SEL   = 1;
  localparam int unsigned T2_CAP_SEL   = 0;
  // Timers three/four control bits; timer four sits four bits up
  localparam int unsigned T3_OVF_FLAG  = 3;
  localparam int unsigned T3_MODE      = 2;
  localparam int unsigned T3_RUN       = 1;
  localparam int unsigned T3_IRQ_EN    = 0;
  localparam int unsigned T4_OFS       = 4;
  // Timer five control bits
  localparam int unsigned T5_OVF_FLAG  = 7;
  localparam int unsigned T5_CLK_SEL_H = 6;
  localparam int unsigned T5_MODE      = 4;
  localparam int unsigned T5_RUN       = 3;
  localparam int unsigned T5_IRQ_EN    = 0;
  localparam logic [7:0]  T5_CTRL_MASK = 8'hf9;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and cycle counts
  localparam logic [7:0]  REG_RST      = 8'h00;
  localparam logic [2:0]  PIN_SYNC_RST = 3'h7;
  localparam logic [2:0]  OSC_SYNC_RST = 3'h0;
  localparam logic [3:0]  T2_DIV_STD   = 4'hc;
  localparam logic [3:0]  T2_DIV_BAUD  = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } rctim_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rctim_apb_rsp_t;

  typedef struct packed {
    logic [7:0]  t2_ctrl;
    logic [15:0] t2_cnt;
    logic [15:0] t2_rld;
    logic [3:0]  t2_pre;
    logic [2:0]  t2_pin;
    logic [7:0]  t34_ctrl;
    logic [15:0] t3_cnt;
    logic [15:0] t3_rld;
    logic [15:0] t4_cnt;
    logic [15:0] t4_rld;
    logic [7:0]  t5_ctrl;
    logic [23:0] t5_cnt;
    logic [23:0] t5_rld;
    logic [2:0]  fast_sync;
    logic [2:0]  slow_sync;
    logic        rx_tick;
    logic        tx_tick;
    logic [31:0] prdata;
    logic        pslverr;
  } rctim_state_t;

endpackage

/* File: tb/rctim_top_test.sv */
/*
  Self-checking testbench for the reload/capture timer set: APB tasks
  and register sequences with expected values for timers two to five.
  Assumes a zero wait state APB slave and byte registers at 4*index.
*/
`timescale 1ns/1ns
module rctim_top_test
  import rctim_pkg::*;
;
  logic           clock_i   = 1'b0;
  logic           rst_i     = 1'b1;
  rctim_apb_req_t apb_i     = '0;
  rctim_apb_rsp_t apb_o;
  logic           pin       = 1'b1;
  logic           fosc      = 1'b0;
  logic           sosc      = 1'b0;
  logic           t1ov      = 1'b0;
  logic           rx_tick, tx_tick, irq2, irq3, irq4, irq5, slverr;
  logic [7:0]     q, a;
  int             err_total = 0;
  int             n_checks  = 0;
  int             rx_n      = 0;
  int             tx_n      = 0;
  int             rx_b      = 0;
  int             tx_b      = 0;
  logic [17:0]    regs [14] = '{18'h2b0, 18'h2b4, 18'h2b8, 18'h2bc, 18'h320, 18'h328,
    18'h32c, 18'h330, 18'h334, 18'h33c, 18'h281a0, 18'h281a4, 18'h281a8, 18'h281ac};

  always #5 clock_i = ~clock_i;
  // Oscillators unrelated in phase to the system clock
  always #23 fosc = ~fosc;
  always #157 sosc = ~sosc;
  always @(posedge clock_i) begin
    rx_n += int'(rx_tick);
    tx_n += int'(tx_tick);
  end

  rctim_top uut (.clock_i(clock_i), .rst_i(rst_i), .apb_i(apb_i), .apb_o(apb_o),
    .timer2_count_pin_i(pin), .fast_internal_osc_i(fosc), .slow_32k_osc_i(sosc),
    .timer1_overflow_i(t1ov), .rx_baud_tick_o(rx_tick), .tx_baud_tick_o(tx_tick),
    .timer2_irq_o(irq2), .timer3_irq_o(irq3), .timer4_irq_o(irq4), .timer5_irq_o(irq5));

  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // One falling edge on the shared pin, long enough for the synchroniser
  task fall;
    pin <= 1'b0;
    wt(4);
    pin <= 1'b1;
    wt(4);
  endtask

  // One idle cycle after each transfer keeps drivers single per time step
  task apb(input logic w, input logic [17:0] ad, input logic [7:0] wd);
    apb_i.psel    <= 1'b1;
    apb_i.penable <= 1'b0;
    apb_i.pwrite  <= w;
    apb_i.paddr   <= ad;
    apb_i.pwdata  <= {24'h0, wd};
    @(posedge clock_i);
    apb_i.penable <= 1'b1;
    @(posedge clock_i);
    while (apb_o.pready !== 1'b1)
      @(posedge clock_i);
    q = apb_o.prdata[7:0];
    slverr = apb_o.pslverr;
    apb_i.psel    <= 1'b0;
    apb_i.penable <= 1'b0;
    @(posedge clock_i);
  endtask

  task wr(input logic [17:0] ad, input logic [7:0] wd);
    apb(1'b1, ad, wd);
  endtask

  task rd(input string nm, input logic [17:0] ad, input logic [7:0] exp);
    apb(1'b0, ad, 8'h00);
    chk(nm, exp, q);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Timer three (t=0, reload mode) or four (t=1, free-run)
  task t34(input int t);
    logic [17:0] b;
    logic [7:0]  md;
    int          sh;
    b  = t ? 18'h2b0 : 18'h2b8;
    sh = t * 4;
    md = t ? 8'h00 : 8'h04;
    wr(18'h33c, 8'h00);
    wr(b + 18'h4, 8'hff);
    wr(b, 8'hf0);
    wr(18'h33c, md << sh);
    if (t == 0) begin
      wr(b + 18'h4, 8'h12);
      wr(b, 8'h34);
    end
    wr(18'h33c, (md | 8'h03) << sh);
    wt(30);
    chk("overflow irq", 1'b1, t ? irq4 : irq3);
    rd("t34 control", 18'h33c, (md | 8'h0b) << sh);
    rd("count high", b + 18'h4, t ? 8'h00 : 8'h12);
    wr(18'h33c, (md | 8'h01) << sh);
    apb(1'b0, b, 8'h00);
    a = q;
    wt(5);
    apb(1'b0, b, 8'h00);
    chk("held count", a, q);
    chk("cleared irq", 1'b0, t ? irq4 : irq3);
    wr(18'h33c, (md | 8'h08) << sh);
    wt(1);
    chk("masked irq", 1'b0, t ? irq4 : irq3);
    wr(18'h33c, 8'h00);
    $display("timer %0d test done", t + 3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wt(20);
    rst_i <= 1'b0;
    wt(2);
    for (int i = 0; i < 14; i++)
      rd("reset value", regs[i], 8'h00);
    apb(1'b0, 18'h340, 8'h00);
    chk("unmapped error", 1'b1, slverr);
    apb(1'b0, 18'h2b1, 8'h00);
    chk("misaligned error", 1'b1, slverr);
    $display("register test done");
    t34(0);
    t34(1);
    wr(18'h328, 8'hcd);
    wr(18'h32c, 8'hab);
    wr(18'h334, 8'hff);
    wr(18'h330, 8'hfe);
    wr(18'h320, 8'h04);
    wt(40);
    rd("t2 control", 18'h320, 8'h84);
    chk("t2 irq", 1'b1, irq2);
    rd("t2 reloaded", 18'h334, 8'hab);
    apb(1'b0, 18'h330, 8'h00);
    a = q;
    wt(117);
    apb(1'b0, 18'h330, 8'h00);
    chk("t2 steps", 8'h0a, q - a);
    wr(18'h328, 8'h00);
    wr(18'h32c, 8'h00);
    wr(18'h320, 8'h0d);
    pin <= 1'b0;
    wt(8);
    rd("event flag", 18'h320, 8'h4d);
    rd("captured", 18'h32c, 8'hab);
    pin <= 1'b1;
    wr(18'h320, 8'h00);
    rx_b = rx_n;
    tx_b = tx_n;
    repeat (3) begin
      t1ov <= 1'b1;
      wt(1);
      t1ov <= 1'b0;
      wt(3);
    end
    chk("timer1 ticks", 1'b1, rx_n - rx_b == 3 && tx_n - tx_b == 3);
    wr(18'h328, 8'hf0);
    wr(18'h32c, 8'hff);
    wr(18'h330, 8'hf0);
    wr(18'h334, 8'hff);
    rx_b = rx_n;
    tx_b = tx_n;
    wr(18'h320, 8'h34);
    wt(200);
    rx_b = rx_n - rx_b;
    tx_b = tx_n - tx_b;
    chk("baud ticks", 1'b1, rx_b >= 5 && rx_b <= 7 && tx_b == rx_b);
    rd("baud no flag", 18'h320, 8'h34);
    wr(18'h320, 8'h00);
    wr(18'h330, 8'h00);
    wr(18'h334, 8'h00);
    wr(18'h320, 8'h06);
    repeat (3) fall;
    rd("pin counts", 18'h330, 8'h03);
    wr(18'h320, 8'h02);
    fall;
    rd("stopped t2", 18'h330, 8'h03);
    wr(18'h328, 8'h55);
    wr(18'h32c, 8'h00);
    wr(18'h320, 8'h0e);
    fall;
    rd("event reload", 18'h330, 8'h55);
    rd("reload event flag", 18'h320, 8'h4e);
    wr(18'h320, 8'h00);
    $display("timer 2 test done");
    wr(18'h281ac, 8'hff);
    wr(18'h281a8, 8'hff);
    wr(18'h281a4, 8'hf0);
    wr(18'h281a0, 8'h09);
    wt(150);
    chk("t5 irq", 1'b1, irq5);
    rd("t5 control", 18'h281a0, 8'h89);
    rd("t5 wrapped", 18'h281ac, 8'h00);
    wr(18'h281a0, 8'h4e);
    rd("t5 slow ctrl", 18'h281a0, 8'h48);
    apb(1'b0, 18'h281a4, 8'h00);
    a = q;
    wt(97);
    apb(1'b0, 18'h281a4, 8'h00);
    a = q - a;
    chk("slow steps", 1'b1, a >= 8'h02 && a <= 8'h05);
    wr(18'h281a0, 8'h00);
    wr(18'h281ac, 8'hff);
    wr(18'h281a8, 8'hff);
    wr(18'h281a4, 8'hf0);
    wr(18'h281a0, 8'h10);
    wr(18'h281ac, 8'h00);
    wr(18'h281a8, 8'hab);
    wr(18'h281a4, 8'h00);
    rd("t5 live kept", 18'h281ac, 8'hff);
    wr(18'h281a0, 8'h18);
    wt(150);
    rd("t5 reloaded", 18'h281a8, 8'hab);
    rd("t5 reload ctrl", 18'h281a0, 8'h98);
    chk("t5 masked irq", 1'b0, irq5);
    $display("timer 5 test done");
    finish_test;
  end

  initial begin
    wt(30000);
    err_total++;
    $display("watchdog expired");
    finish_test;
  end
endmodule
